// ===== design/nand_host.sv
`timescale 1ns/100ps
`default_nettype none
module nand_host
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // user request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [2:0] req_op_in,
  input wire logic [7:0] req_byte_in,
  input wire logic [COL_W-1:0] req_col_in,
  input wire logic [ROW_W-1:0] req_row_in,
  input wire logic wp_allow_in,
  // user answer
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic [2:0] id5_planes_log2_out,
  output logic [2:0] id5_size_code_out,
  output logic busy_out,
  // flash pins
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic wp_n_out,
  input wire logic rb_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_out
);
  typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_RLOW, ST_RHIGH} st_e;
  st_e st, next_st; // bus phase
  op_e op, next_op; // current operation
  logic [2:0] cnt, next_cnt; // phase clock count
  logic [2:0] idx, next_idx; // byte index within operation
  logic [7:0] io, next_io; // driven byte
  logic cle, next_cle, ale, next_ale, oe, next_oe;
  logic we_n, next_we_n, re_n, next_re_n;
  logic [COL_W-1:0] col, next_col; // latched column
  logic [ROW_W-1:0] row, next_row; // latched row
  logic [7:0] rsp, next_rsp;
  logic rsp_v, next_rsp_v;
  logic [2:0] pl, next_pl, sz, next_sz;
  logic after_id, next_after_id; // id mode still active in device
  logic rb_level, phase_done; // filtered ready level, phase end

  // filtered ready/busy pin, low is busy
  pin_sync u_rb (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(rb_n_in),
    .level_out(rb_level)
  );
  //////////////////////////////////////////////////////////////////////
  // address cycle byte, column low first then row
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
      input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r);
    logic [30:0] a;
    a = {r, c};
    case (i)
      3'h0: addr_byte = a[7:0];
      3'h1: addr_byte = {HIGH_NIBBLE_LOW, a[11:8]};
      3'h2: addr_byte = a[19:12];
      3'h3: addr_byte = a[27:20];
      3'h4: addr_byte = {CYC5_UPPER_LOW, a[30:28]};
      default: addr_byte = 8'h00;
    endcase
  endfunction
  // die status command from row msb
  function automatic logic [7:0] die_cmd(input logic [ROW_W-1:0] r);
    die_cmd = r[DIE_ROW_BIT] ? CMD_STATUS_DIE1 : CMD_STATUS_DIE0;
  endfunction
  assign phase_done = (cnt == PHASE_LAST);
  // no request is offered a handshake while the filtered ready level is low
  assign req_ready_out = (st == ST_IDLE) && rb_level;
  //////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    next_st = st;
    next_op = op;
    next_cnt = phase_done ? 3'h0 : cnt + 3'h1;
    next_idx = idx;
    next_io = io;
    next_cle = cle;
    next_ale = ale;
    next_oe = oe;
    next_we_n = we_n;
    next_re_n = re_n;
    next_col = col;
    next_row = row;
    next_rsp = rsp;
    next_rsp_v = 1'b0;
    next_pl = pl;
    next_sz = sz;
    next_after_id = after_id;
    case (st)
      ST_IDLE: begin
        next_cnt = 3'h0;
        next_oe = 1'b0;
        next_cle = 1'b0;
        next_ale = 1'b0;
        if (req_valid_in && rb_level) begin // wait while busy
          next_op = op_e'(req_op_in);
          next_idx = 3'h0;
          next_col = req_col_in;
          next_row = req_row_in;
          next_st = ST_SETUP;
          case (op_e'(req_op_in))
            OP_CMD: begin
              // plain status after id needs a dummy first
              if (after_id && req_byte_in == CMD_STATUS) begin
                next_io = CMD_DUMMY;
                next_idx = 3'h7;
              end else begin
                next_io = req_byte_in;
              end
              next_cle = 1'b1;
              next_oe = 1'b1;
              next_after_id = (req_byte_in == CMD_READ_ID);
            end
            OP_ADDR5: begin
              next_io = addr_byte(3'h0, req_col_in, req_row_in);
              next_ale = 1'b1;
              next_oe = 1'b1;
            end
            OP_WRITE: begin
              next_io = req_byte_in;
              next_oe = 1'b1;
            end
            OP_READ_ID: begin
              next_io = CMD_READ_ID;
              next_cle = 1'b1;
              next_oe = 1'b1;
              next_after_id = 1'b1;
            end
            OP_DIE_STATUS: begin
              next_io = die_cmd(req_row_in);
              next_cle = 1'b1;
              next_oe = 1'b1;
              next_after_id = 1'b0;
            end
            default: begin // single read
              next_st = ST_RLOW;
            end
          endcase
        end
      end
      ST_SETUP: begin // setup before strobe
        if (phase_done) begin
          next_we_n = 1'b0;
          next_st = ST_LOW;
        end
      end
      ST_LOW: begin // strobe low phase
        if (phase_done) begin
          next_we_n = 1'b1; // rising edge latches
          next_st = ST_HIGH;
        end
      end
      ST_HIGH: begin // hold, then next byte
        if (phase_done) begin
          next_st = ST_IDLE;
          next_cle = 1'b0;
          next_ale = 1'b0;
          next_oe = 1'b0;
          if (op == OP_CMD && idx == 3'h7) begin
            next_idx = 3'h0;
            next_io = CMD_STATUS; // real status follows
            next_cle = 1'b1;
            next_oe = 1'b1;
            next_st = ST_SETUP;
          end else if (op == OP_ADDR5 && idx != 3'(ADDR_CYCLES - 1)) begin
            next_idx = idx + 3'h1;
            next_io = addr_byte(idx + 3'h1, col, row);
            next_ale = 1'b1;
            next_oe = 1'b1;
            next_st = ST_SETUP;
          end else if (op == OP_READ_ID && idx == 3'h0) begin
            next_idx = 3'h1;
            next_io = ID_ADDR;
            next_ale = 1'b1;
            next_oe = 1'b1;
            next_st = ST_SETUP;
          end else if (op == OP_READ_ID) begin
            next_idx = 3'h0;
            next_st = ST_RLOW; // begin id byte reads
          end
        end
      end
      ST_RLOW: begin // read strobe low, device drives bus
        next_re_n = 1'b0;
        if (phase_done) begin
          next_rsp = io_in;
          next_rsp_v = 1'b1;
          next_re_n = 1'b1;
          next_st = ST_RHIGH;
          if (op == OP_READ_ID && idx == 3'(ID_BYTES - 1)) begin
            next_pl = {1'b0, io_in[ID5_PLANES_LO +: 2]};
            next_sz = io_in[ID5_SIZE_LO +: 3];
          end
        end
      end
      ST_RHIGH: begin // read recovery
        if (phase_done) begin
          next_st = ST_IDLE;
          if (op == OP_READ_ID && idx != 3'(ID_BYTES - 1)) begin
            next_idx = idx + 3'h1;
            next_st = ST_RLOW;
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= ST_IDLE;
      op <= OP_CMD;
      cnt <= 3'h0;
      idx <= 3'h0;
      io <= 8'h00;
      cle <= 1'b0;
      ale <= 1'b0;
      oe <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      col <= '0;
      row <= '0;
      rsp <= 8'h00;
      rsp_v <= 1'b0;
      pl <= 3'h0;
      sz <= 3'h0;
      after_id <= 1'b0;
    end else begin
      st <= next_st;
      op <= next_op;
      cnt <= next_cnt;
      idx <= next_idx;
      io <= next_io;
      cle <= next_cle;
      ale <= next_ale;
      oe <= next_oe;
      we_n <= next_we_n;
      re_n <= next_re_n;
      col <= next_col;
      row <= next_row;
      rsp <= next_rsp;
      rsp_v <= next_rsp_v;
      pl <= next_pl;
      sz <= next_sz;
      after_id <= next_after_id;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin drive; cle and ale never both set
  assign ce_n_out = 1'b0;
  assign cle_out = cle;
  assign ale_out = ale & ~cle;
  assign we_n_out = we_n;
  assign re_n_out = re_n;
  assign wp_n_out = wp_allow_in;
  assign io_out = io;
  assign io_oe_out = oe & re_n;
  assign rsp_valid_out = rsp_v;
  assign rsp_byte_out = rsp;
  assign id5_planes_log2_out = pl;
  assign id5_size_code_out = sz;
  assign busy_out = ~rb_level;
endmodule // nand_host
`default_nettype wire

// ===== design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage input filter; change accepted when stages two and three agree
module pin_sync
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] stage; // shift chain
  logic next_level; // filtered value

  //////////////////////////////////////////////////////////////////////
  // next value
  always_comb begin
    next_level = level_out;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  // registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage <= 3'h7;
      level_out <= 1'b1;
    end else begin
      stage <= {stage[1:0], pin_in};
      level_out <= next_level;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ===== pkg/nand_host_pkg.sv
package nand_host_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_DUMMY = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_DIE0 = 8'hF2;
  localparam logic [7:0] CMD_STATUS_DIE1 = 8'hF3;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // address field widths and positions
  localparam int COL_W = 12;
  localparam int ROW_W = 19;
  localparam int ADDR_CYCLES = 5;
  localparam int ID_BYTES = 5;
  localparam int DIE_ROW_BIT = 18;
  localparam logic [3:0] HIGH_NIBBLE_LOW = 4'h0;
  localparam logic [4:0] CYC5_UPPER_LOW = 5'h00;
  // fifth id byte fields
  localparam int ID5_PLANES_LO = 2;
  localparam int ID5_SIZE_LO = 4;
  // strobe phase length in clocks (10 ns each)
  localparam int PHASE_NS = 30;
  localparam int CLK_NS = 10;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] PHASE_LAST = 3'(PHASE_CYC - 1);
  // operation kinds requested by the user
  typedef enum logic [2:0] {
    OP_CMD, OP_ADDR5, OP_WRITE, OP_READ, OP_READ_ID, OP_DIE_STATUS
  } op_e;
endpackage

// ===== verification/nand_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural flash device facing the host
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter logic [39:0] ID_CODE = 40'h5A3C817E64 // arbitrary id bytes
) (
  // strobes and bus from host
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic wp_n_in,
  input wire logic busy_in,
  input wire logic [7:0] io_in,
  // device bus side and observed state
  output logic [7:0] io_out,
  output logic io_oe_out,
  output logic rb_n_out,
  output logic [7:0] cmd_out,
  output logic [4:0][7:0] adr_out,
  output logic seq_err_out
);
  int na; // address byte index
  int k; // read byte index
  logic idm; // identification mode
  initial begin
    {cmd_out, adr_out, io_out, seq_err_out, idm} = '0;
    na = 0;
    k = 0;
  end
  // latch on we rising edge, bus ignored while busy
  always @(posedge we_n_in) begin
    if (!ce_n_in && !busy_in) begin
      if (cle_in) begin
        if (io_in == CMD_STATUS && cmd_out == CMD_READ_ID) seq_err_out = 1;
        cmd_out = io_in;
        na = 0;
        k = 0;
        idm = 0;
      end else if (ale_in) begin
        adr_out[na] = io_in;
        if (cmd_out == CMD_READ_ID && io_in == ID_ADDR) idm = 1;
        na = (na + 1) % ADDR_CYCLES;
      end
    end
  end
  // each re fall gives the next byte
  always @(negedge re_n_in) begin
    if (idm && k < ID_BYTES) io_out = ID_CODE[39-8*k -: 8];
    else io_out = {wp_n_in, 6'h20, cmd_out == CMD_STATUS_DIE1};
    k = k + 1;
  end
  assign io_oe_out = !re_n_in && !ce_n_in;
  assign rb_n_out = !busy_in;
endmodule // nand_flash_model
`default_nettype wire

// ===== verification/nand_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// pin protocol checks on the host top module
module nand_host_monitor (
  // clock, reset, user side
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wp_allow_in,
  input wire logic rsp_valid_out,
  input wire logic busy_out,
  // flash pins
  input wire logic ce_n_out,
  input wire logic cle_out,
  input wire logic ale_out,
  input wire logic we_n_out,
  input wire logic re_n_out,
  input wire logic wp_n_out,
  input wire logic rb_n_in,
  input wire logic [7:0] io_out,
  input wire logic io_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_ONE_LATCH: assert property (!(cle_out && ale_out))
    else $error("cle and ale high together");
  AST_SELECT: assert property (!ce_n_out)
    else $error("device not selected");
  AST_PROTECT: assert property (wp_n_out == wp_allow_in)
    else $error("write protect not following request");
  AST_WE_HOLD: assert property ($rose(we_n_out) |-> io_oe_out
    && $stable(io_out) && $stable(cle_out) && $stable(ale_out))
    else $error("bus or latch enables moved at we rise");
  AST_NO_FIGHT: assert property (!re_n_out |-> !io_oe_out)
    else $error("host drives bus during read strobe");
  AST_STROBES: assert property (!(!we_n_out && !re_n_out))
    else $error("we and re low together");
  AST_READ_ANS: assert property ($rose(re_n_out) |-> rsp_valid_out)
    else $error("read strobe without answer");
  AST_BUSY: assert property ((!rb_n_in) [*6] |-> busy_out)
    else $error("busy line not seen");
endmodule // nand_host_monitor
bind nand_host nand_host_monitor i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .wp_allow_in(wp_allow_in), .rsp_valid_out(rsp_valid_out),
  .busy_out(busy_out), .ce_n_out(ce_n_out), .cle_out(cle_out),
  .ale_out(ale_out), .we_n_out(we_n_out), .re_n_out(re_n_out),
  .wp_n_out(wp_n_out), .rb_n_in(rb_n_in), .io_out(io_out),
  .io_oe_out(io_oe_out));
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import nand_host_pkg::*;;
  localparam logic [39:0] ID_CODE = 40'h5A3C817E64; // arbitrary id bytes
  logic clk, rst_n, req_valid, req_ready, wp_allow, busy, rsp_valid, busy_o;
  logic ce_n, cle, ale, we_n, re_n, wp_n, rb_n, io_oe, dev_oe, seq_err;
  logic [2:0] req_op, planes, size;
  logic [7:0] req_byte, rsp_byte, io_h, dev_io, cmd, b;
  logic [11:0] req_col, c;
  logic [18:0] req_row, r;
  logic [4:0][7:0] adr;
  wire [7:0] bus = dev_oe ? dev_io : io_oe ? io_h : ~dev_io;
  logic [7:0] q[$]; // expected answers
  int n_checks = 0;
  int n_mismatch = 0;
  nand_host i_nand_host (.clk_in(clk), .rst_n_in(rst_n),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_op_in(req_op),
    .req_byte_in(req_byte), .req_col_in(req_col), .req_row_in(req_row),
    .wp_allow_in(wp_allow), .rsp_valid_out(rsp_valid),
    .rsp_byte_out(rsp_byte), .id5_planes_log2_out(planes),
    .id5_size_code_out(size), .busy_out(busy_o), .ce_n_out(ce_n),
    .cle_out(cle), .ale_out(ale), .we_n_out(we_n), .re_n_out(re_n),
    .wp_n_out(wp_n), .rb_n_in(rb_n), .io_in(bus), .io_out(io_h),
    .io_oe_out(io_oe));
  nand_flash_model #(.ID_CODE(ID_CODE)) i_nand_flash_model (.ce_n_in(ce_n),
    .cle_in(cle), .ale_in(ale), .we_n_in(we_n), .re_n_in(re_n),
    .wp_n_in(wp_n), .busy_in(busy), .io_in(bus), .io_out(dev_io),
    .io_oe_out(dev_oe), .rb_n_out(rb_n), .cmd_out(cmd), .adr_out(adr),
    .seq_err_out(seq_err));
  always #5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one request, wait until idle again
  task automatic go(input op_e op, input logic [7:0] d, input logic [18:0] w);
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    req_op = 3'(op);
    req_byte = d;
    req_row = w;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // answer watcher takes oldest note
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) chk(19'h7FFFF, 19'h0);
      else chk(19'(rsp_byte), 19'(q.pop_front()));
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    $display("unexpected %0t timeout", $time);
    summarize();
  end
  initial begin
    {clk, rst_n, req_valid, req_op, req_byte, req_col, req_row, busy} = '0;
    wp_allow = 1;
    void'($urandom(32'hEBE7));
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < ID_BYTES; i++) q.push_back(ID_CODE[39-8*i -: 8]);
    go(OP_READ_ID, 8'h00, 19'h0);
    chk(19'(planes), 19'h1);
    chk(19'(size), 19'h6);
    wp_allow = 1'($urandom);
    go(OP_CMD, CMD_STATUS, 19'h0);
    chk(19'(seq_err), 19'h0);
    q.push_back({wp_allow, 6'h20, 1'b0});
    go(OP_READ, 8'h00, 19'h0);
    $display("test id and status done");
    for (int i = 0; i < 4; i++) begin
      c = 12'($urandom);
      r = 19'($urandom);
      req_col = c;
      go(OP_ADDR5, 8'h00, r);
      chk(19'(adr[0]), 19'(c[7:0]));
      chk(19'(adr[1]), 19'({4'h0, c[11:8]}));
      chk(19'(adr[2]), 19'(r[7:0]));
      chk(19'(adr[3]), 19'(r[15:8]));
      chk(19'(adr[4]), 19'({5'h00, r[18:16]}));
    end
    $display("test address done");
    for (int d = 0; d < 2; d++) begin
      r = {d[0], 18'($urandom)};
      go(OP_DIE_STATUS, 8'h00, r);
      chk(19'(cmd), 19'(d[0] ? CMD_STATUS_DIE1 : CMD_STATUS_DIE0));
      q.push_back({wp_allow, 6'h20, d[0]});
      go(OP_READ, 8'h00, 19'h0);
    end
    b = 8'($urandom);
    go(OP_CMD, b, 19'h0);
    chk(19'(cmd), 19'(b));
    go(OP_WRITE, ~b, 19'h0);
    chk(19'(cmd), 19'(b));
    $display("test die status and command done");
    busy = 1;
    repeat (6) @(negedge clk);
    chk(19'(busy_o), 19'h1);
    chk(19'(req_ready), 19'h0);
    busy = 0;
    repeat (6) @(negedge clk);
    chk(19'(busy_o), 19'h0);
    chk(19'(req_ready), 19'h1);
    $display("test busy done");
    chk(19'(q.size()), 19'h0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
